// ==== tb/pgt_mask_bank_asserts.sv ====
// Purpose: Port-level checks of the power-good mask bank
// Assumes: One clock domain, reset active low
// Notes:   Masks are internal, so only mask-independent cases are checked
`timescale 1ns/100ps
module pgt_mask_bank_asserts (
  input wire logic                clock,
  input wire logic                nrst,
  input wire logic                scl_in,
  input wire logic                sda_oe,
  input wire logic                sda_out,
  input wire pgt_pkg::pgt_rails_t rails,
  input wire pgt_pkg::pgt_ctl_t   ctl,
  input wire logic [3:0]          other_pg_ok,
  input wire logic                pg_output_one,
  input wire logic                pg_output_two,
  input wire logic                pg_output_three,
  input wire logic                pg_output_four
);
  import pgt_pkg::*;
  // ****************
  // Properties
  // ****************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  sequence s_all_good;
    (rails == 4'hf) && (ctl == 6'h3f) && (other_pg_ok == 4'hf);
  endsequence
  sequence s_in36(logic ok);
    ok && ctl.control_input_three && ctl.control_input_six;
  endsequence

  property p_all_good;
    s_all_good |=> pg_output_one && pg_output_two && pg_output_three && pg_output_four;
  endproperty
  a_all_good: assert property (p_all_good)
    else $error("output low with every source good");
  property p_out1_good;
    s_in36(other_pg_ok[0]) |=> pg_output_one;
  endproperty
  a_out1_good: assert property (p_out1_good)
    else $error("output one low with its sources good");
  property p_out2_good;
    s_in36(other_pg_ok[1]) |=> pg_output_two;
  endproperty
  a_out2_good: assert property (p_out2_good)
    else $error("output two low with its sources good");
  property p_out4_good;
    s_in36(other_pg_ok[3]) |=> pg_output_four;
  endproperty
  a_out4_good: assert property (p_out4_good)
    else $error("output four low with its sources good");
  property p_out1_low;
    !other_pg_ok[0] |=> !pg_output_one;
  endproperty
  a_out1_low: assert property (p_out1_low)
    else $error("output one high with a bad source");
  property p_out2_low;
    !other_pg_ok[1] |=> !pg_output_two;
  endproperty
  a_out2_low: assert property (p_out2_low)
    else $error("output two high with a bad source");
  property p_out3_low;
    !other_pg_ok[2] |=> !pg_output_three;
  endproperty
  a_out3_low: assert property (p_out3_low)
    else $error("output three high with a bad source");
  property p_out4_low;
    !other_pg_ok[3] |=> !pg_output_four;
  endproperty
  a_out4_low: assert property (p_out4_low)
    else $error("output four high with a bad source");
  property p_sda_low;
    sda_out == 1'b0;
  endproperty
  a_sda_low: assert property (p_sda_low)
    else $error("data pin driven high");
  property p_oe_steady;
    $changed(sda_oe) |-> !scl_in;
  endproperty
  a_oe_steady: assert property (p_oe_steady)
    else $error("data pin enable changed while serial clock high");
endmodule

// ==== tb/testbench.sv ====
// Purpose: Self-checking bench of the power-good mask bank
// Assumes: Serial host driven by the bench, inputs change at falling edge
// Notes:   Scenario tasks each judge their own results
`timescale 1ns/100ps
`include "pgt_regs.svh"
module testbench;
  import pgt_pkg::*;
  logic       clock;
  logic       nrst;
  logic       scl;
  logic       sda_drv;
  logic       sda_out;
  logic       sda_oe;
  logic       dis;
  pgt_rails_t rails;
  pgt_ctl_t   ctl;
  logic [3:0] other_pg_ok;
  logic [3:0] pg;
  logic [7:0] rx;
  logic       a;
  int         err_count;
  int         n_tests;
  wire        sda_line;
  assign sda_line = sda_drv & ~sda_oe;

  pgt_mask_bank DUT (
    .clock                        (clock),
    .nrst                         (nrst),
    .scl_in                       (scl),
    .sda_in                       (sda_line),
    .sda_out                      (sda_out),
    .sda_oe                       (sda_oe),
    .rails                        (rails),
    .ctl                          (ctl),
    .other_pg_ok                  (other_pg_ok),
    .pg_output_one                (pg[0]),
    .pg_output_two                (pg[1]),
    .pg_output_three              (pg[2]),
    .pg_output_four               (pg[3]),
    .termination_discharge_enable (dis)
  );

  // ****************
  // Bus tasks
  // ****************
  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bit_io(input logic b, output logic r);
    sda_drv = b;
    tick(3);
    scl = 1'b1;
    tick(2);
    r = sda_line;
    tick(2);
    scl = 1'b0;
    tick(1);
  endtask
  task automatic byte_io(input logic [7:0] tx, input logic ak, output logic [7:0] d,
                         output logic ra);
    logic b;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(tx[i], b);
      d[i] = b;
    end
    bit_io(ak, ra);
  endtask
  task automatic start;
    sda_drv = 1'b1;
    tick(2);
    scl = 1'b1;
    tick(3);
    sda_drv = 1'b0;
    tick(3);
    scl = 1'b0;
    tick(1);
  endtask
  task automatic stop;
    sda_drv = 1'b0;
    tick(2);
    scl = 1'b1;
    tick(3);
    sda_drv = 1'b1;
    tick(3);
  endtask
  task automatic send(input logic [7:0] tx);
    byte_io(tx, 1'b1, rx, a);
    chk({7'h0, a}, 8'h00);
  endtask
  task automatic wr(input logic [7:0] ofs, input logic [7:0] d0, input logic [7:0] d1,
                    input int n);
    start;
    send({`PGT_DEV_ADDR, 1'b0});
    send(ofs);
    send(d0);
    if (n > 1)
      send(d1);
    stop;
  endtask
  task automatic rd(input logic [7:0] ofs, output logic [7:0] d);
    start;
    send({`PGT_DEV_ADDR, 1'b0});
    send(ofs);
    start;
    send({`PGT_DEV_ADDR, 1'b1});
    byte_io(8'hff, 1'b1, d, a);
    stop;
  endtask
  // Source j goes bad, j of 10 leaves all good
  task automatic set_src(input int j);
    logic [9:0] s;
    s = ~(10'h1 << j);
    {ctl.control_input_five, ctl.control_input_four, ctl.control_input_two,
     ctl.control_input_one, rails.termination_regulator,
     rails.shared_switch_or_regulator_rail, rails.load_switch_b_one,
     rails.regulator_a_three} = s[7:0];
    ctl.control_input_three = s[8];
    ctl.control_input_six = s[9];
    tick(2);
  endtask

  // ****************
  // Scenarios
  // ****************
  task automatic t_reset;
    rd(`PGT_OUT3_MASK2_OFS, rx);
    chk(rx, `PGT_OUT3_MASK2_RST);
    rd(`PGT_CTL_MASK_OFS, rx);
    chk(rx, `PGT_CTL_MASK_RST);
    rd(`PGT_DISCH_OFS, rx);
    chk(rx, `PGT_DISCH_RST);
    chk({7'h0, dis}, 8'h01);
    set_src(9);
    chk({4'h0, pg}, 8'h04);
    set_src(10);
  endtask
  // Master-acked read advances the pointer, the final nacked byte does not
  task automatic t_burst;
    logic [7:0] d0;
    logic [7:0] d1;
    start;
    send({`PGT_DEV_ADDR, 1'b0});
    send(`PGT_OUT3_MASK2_OFS);
    start;
    send({`PGT_DEV_ADDR, 1'b1});
    byte_io(8'hff, 1'b0, d0, a);
    byte_io(8'hff, 1'b1, d1, a);
    stop;
    chk(d0, `PGT_OUT3_MASK2_RST);
    chk(d1, `PGT_CTL_MASK_RST);
    start;
    send({`PGT_DEV_ADDR, 1'b1});
    byte_io(8'hff, 1'b1, d0, a);
    stop;
    chk(d0, `PGT_CTL_MASK_RST);
  endtask
  task automatic t_masks;
    for (int j = 0; j < 10; j++)
    begin
      wr(`PGT_OUT3_MASK2_OFS, 8'h00, 8'h00, 2);
      set_src(j);
      chk({4'h0, pg}, (j < 8) ? 8'h0b : 8'h00);
      wr(`PGT_OUT3_MASK2_OFS, (j < 8) ? 8'h01 << j : 8'h00,
         (j == 8) ? 8'haa : ((j == 9) ? 8'h55 : 8'h00), 2);
      tick(2);
      chk({4'h0, pg}, 8'h0f);
    end
    set_src(10);
  endtask
  task automatic t_other;
    for (int i = 0; i < 4; i++)
    begin
      other_pg_ok = ~(4'h1 << i);
      tick(2);
      chk({4'h0, pg}, {4'h0, ~(4'h1 << i)});
    end
    other_pg_ok = 4'hf;
  endtask
  task automatic t_disch;
    // Reserved bits are written back with their factory values
    wr(`PGT_DISCH_OFS, 8'h4f, 8'h00, 1);
    chk({7'h0, dis}, 8'h00);
    rd(`PGT_DISCH_OFS, rx);
    chk(rx, 8'h4f);
    wr(`PGT_DISCH_OFS, 8'h5f, 8'h00, 1);
    chk({7'h0, dis}, 8'h01);
  endtask
  task automatic t_refuse;
    rd(8'h10, rx);
    chk(rx, 8'h00);
    start;
    byte_io({`PGT_DEV_ADDR ^ 7'h01, 1'b0}, 1'b1, rx, a);
    chk({7'h0, a}, 8'h01);
    stop;
  endtask

  task automatic finish_test;
    $display("errors %0d checks %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  initial
  begin
    repeat (100000) @(posedge clock);
    err_count++;
    finish_test;
  end
  initial
  begin
    nrst = 1'b0;
    scl = 1'b1;
    sda_drv = 1'b1;
    rails = 4'hf;
    ctl = 6'h3f;
    other_pg_ok = 4'hf;
    err_count = 0;
    n_tests = 0;
    repeat (6) @(posedge clock);
    @(negedge clock);
    nrst = 1'b1;
    tick(2);
    t_reset;
    t_burst;
    t_masks;
    t_other;
    t_disch;
    t_refuse;
    finish_test;
  end
endmodule

bind pgt_mask_bank pgt_mask_bank_asserts u_chk (
  .clock           (clock),
  .nrst            (nrst),
  .scl_in          (scl_in),
  .sda_oe          (sda_oe),
  .sda_out         (sda_out),
  .rails           (rails),
  .ctl             (ctl),
  .other_pg_ok     (other_pg_ok),
  .pg_output_one   (pg_output_one),
  .pg_output_two   (pg_output_two),
  .pg_output_three (pg_output_three),
  .pg_output_four  (pg_output_four)
);

// ==== verilog/pgt_mask_bank.sv ====
// Purpose: Power-good tree mask registers behind a serial two-wire target
// Assumes: scl_in and sda_in are synchronous to clock
// Notes:   Pointer auto-increments; unmapped reads return 8'h00
`timescale 1ns/100ps
`include "pgt_regs.svh"

module pgt_mask_bank #(
  parameter logic [6:0] DEV_ADDR        = `PGT_DEV_ADDR,
  parameter logic [7:0] OUT3_MASK2_INIT = `PGT_OUT3_MASK2_RST,
  parameter logic [7:0] CTL_MASK_INIT   = `PGT_CTL_MASK_RST,
  parameter logic [7:0] DISCH_INIT      = `PGT_DISCH_RST
) (
  input  wire logic             clock,
  input  wire logic             nrst,
  input  wire logic             scl_in,
  input  wire logic             sda_in,
  output logic                  sda_out,
  output logic                  sda_oe,
  input  wire pgt_pkg::pgt_rails_t rails,
  input  wire pgt_pkg::pgt_ctl_t   ctl,
  input  wire logic [3:0]       other_pg_ok,
  output logic                  pg_output_one,
  output logic                  pg_output_two,
  output logic                  pg_output_three,
  output logic                  pg_output_four,
  output logic                  termination_discharge_enable
);
  import pgt_pkg::*;

  // ****************************************
  // Serial target
  // ****************************************
  pgt_state_t state;
  logic       scl_prev;
  logic       sda_prev;
  logic [3:0] bit_cnt;
  logic [7:0] shift;
  logic [7:0] tx;
  logic       rd_mode;
  logic       master_ack;
  logic [7:0] ptr;
  logic [7:0] output_three_tree_mask_second;
  logic [7:0] control_input_tree_masks;
  logic [7:0] termination_discharge_control;

  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic byte_done;
  logic wr_en;
  logic ptr_load;
  logic rd_next;
  logic [7:0] next_ptr;

  assign scl_rise   = scl_in & ~scl_prev;
  assign scl_fall   = ~scl_in & scl_prev;
  assign start_seen = scl_in & scl_prev & sda_prev & ~sda_in;
  assign stop_seen  = scl_in & scl_prev & ~sda_prev & sda_in;
  assign byte_done  = scl_fall & (bit_cnt == 4'h8);
  assign wr_en      = byte_done & (state == PGT_WDATA);
  assign ptr_load   = byte_done & (state == PGT_PTR);
  assign rd_next    = scl_fall & (state == PGT_RDATA_ACK) & master_ack;
  assign next_ptr   = ptr + 8'h01;

  function automatic logic [7:0] reg_value(input logic [7:0] a);
    case (a)
      `PGT_OUT3_MASK2_OFS: return output_three_tree_mask_second;
      `PGT_CTL_MASK_OFS:   return control_input_tree_masks;
      `PGT_DISCH_OFS:      return termination_discharge_control;
      default:             return 8'h00;
    endcase
  endfunction

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      {scl_prev, sda_prev} <= 2'b11;
    else
      {scl_prev, sda_prev} <= {scl_in, sda_in};
  end

  // Bit counter and receive shifter
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      bit_cnt <= 4'h0;
      shift   <= 8'h00;
    end
    else if (start_seen)
    begin
      bit_cnt <= 4'h0;
      shift   <= 8'h00;
    end
    else if (scl_fall && (state == PGT_ADDR_ACK || state == PGT_PTR_ACK ||
                          state == PGT_WDATA_ACK || state == PGT_RDATA_ACK ||
                          byte_done))
      bit_cnt <= 4'h0;
    else if (state == PGT_RDATA && scl_fall)
      bit_cnt <= bit_cnt + 4'h1;
    else if (scl_rise && (state == PGT_ADDR || state == PGT_PTR || state == PGT_WDATA))
    begin
      shift   <= {shift[6:0], sda_in};
      bit_cnt <= bit_cnt + 4'h1;
    end
  end

  // Transfer sequencing
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      state      <= PGT_IDLE;
      rd_mode    <= 1'b0;
      master_ack <= 1'b0;
      tx         <= 8'hff;
    end
    else if (start_seen)
      state <= PGT_ADDR;
    else if (stop_seen)
      state <= PGT_IDLE;
    else
    begin
      case (state)
        PGT_IDLE:
          state <= PGT_IDLE;
        PGT_ADDR:
          if (byte_done)
          begin
            rd_mode <= shift[0];
            state   <= (shift[7:1] == DEV_ADDR) ? PGT_ADDR_ACK : PGT_IDLE;
          end
        PGT_ADDR_ACK:
          if (scl_fall)
          begin
            if (rd_mode)
            begin
              tx    <= reg_value(ptr);
              state <= PGT_RDATA;
            end
            else
              state <= PGT_PTR;
          end
        PGT_PTR:
          if (byte_done)
            state <= PGT_PTR_ACK;
        PGT_PTR_ACK:
          if (scl_fall)
            state <= PGT_WDATA;
        PGT_WDATA:
          if (byte_done)
            state <= PGT_WDATA_ACK;
        PGT_WDATA_ACK:
          if (scl_fall)
            state <= PGT_WDATA;
        PGT_RDATA:
          if (scl_fall)
          begin
            if (bit_cnt == 4'h7)
            begin
              tx    <= 8'hff;
              state <= PGT_RDATA_ACK;
            end
            else
              tx <= {tx[6:0], 1'b1};
          end
        PGT_RDATA_ACK:
          if (scl_rise)
            master_ack <= ~sda_in;
          else if (scl_fall)
          begin
            if (master_ack)
            begin
              tx    <= reg_value(next_ptr);
              state <= PGT_RDATA;
            end
            else
              state <= PGT_IDLE;
          end
        default:
          state <= PGT_IDLE;
      endcase
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe  = (state == PGT_ADDR_ACK) | (state == PGT_PTR_ACK) |
                   (state == PGT_WDATA_ACK) | ((state == PGT_RDATA) & ~tx[7]);

  // ****************************************
  // Register pointer
  // ****************************************
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      ptr <= 8'h00;
    else if (ptr_load)
      ptr <= shift;
    else if (wr_en || rd_next)
      ptr <= next_ptr;
  end

  // ****************************************
  // Mask and discharge registers
  // ****************************************
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      output_three_tree_mask_second <= OUT3_MASK2_INIT;
      control_input_tree_masks      <= CTL_MASK_INIT;
      termination_discharge_control <= DISCH_INIT;
    end
    else if (wr_en)
    begin
      case (ptr)
        `PGT_OUT3_MASK2_OFS: output_three_tree_mask_second <= shift;
        `PGT_CTL_MASK_OFS:   control_input_tree_masks      <= shift;
        // Reserved bits are stored as written by software
        `PGT_DISCH_OFS:      termination_discharge_control <= shift;
        default:             ;
      endcase
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      termination_discharge_enable <= DISCH_INIT[`PGT_DISCH_BIT];
    else
      termination_discharge_enable <= termination_discharge_control[`PGT_DISCH_BIT];
  end

  // ****************************************
  // Power-good trees
  // ****************************************
  logic [9:0] out3_src;
  logic [9:0] out3_msk;
  assign out3_src = {ctl.control_input_five, ctl.control_input_four,
                     ctl.control_input_two, ctl.control_input_one,
                     rails.termination_regulator, rails.shared_switch_or_regulator_rail,
                     rails.load_switch_b_one, rails.regulator_a_three,
                     ctl.control_input_three, ctl.control_input_six};
  assign out3_msk = {output_three_tree_mask_second,
                     control_input_tree_masks[`PGT_O3_IN3_MSK],
                     control_input_tree_masks[`PGT_O3_IN6_MSK]};

  pgt_tree #(.N(10)) u_tree_three (
    .clock   (clock),
    .nrst    (nrst),
    .src     (out3_src),
    .mask    (out3_msk),
    .base_ok (other_pg_ok[2]),
    .pg      (pg_output_three)
  );

  pgt_tree #(.N(2)) u_tree_one (
    .clock   (clock),
    .nrst    (nrst),
    .src     ({ctl.control_input_three, ctl.control_input_six}),
    .mask    (control_input_tree_masks[`PGT_O1_IN3_MSK:`PGT_O1_IN6_MSK]),
    .base_ok (other_pg_ok[0]),
    .pg      (pg_output_one)
  );

  pgt_tree #(.N(2)) u_tree_four (
    .clock   (clock),
    .nrst    (nrst),
    .src     ({ctl.control_input_three, ctl.control_input_six}),
    .mask    (control_input_tree_masks[`PGT_O4_IN3_MSK:`PGT_O4_IN6_MSK]),
    .base_ok (other_pg_ok[3]),
    .pg      (pg_output_four)
  );

  pgt_tree #(.N(2)) u_tree_two (
    .clock   (clock),
    .nrst    (nrst),
    .src     ({ctl.control_input_three, ctl.control_input_six}),
    .mask    (control_input_tree_masks[`PGT_O2_IN3_MSK:`PGT_O2_IN6_MSK]),
    .base_ok (other_pg_ok[1]),
    .pg      (pg_output_two)
  );
endmodule

// ==== verilog/pgt_pkg.sv ====
// Purpose: Types shared by the mask bank files
// Assumes: Nothing
// Notes:   States are Gray coded along the write path
package pgt_pkg;

  typedef enum logic [3:0] {
    PGT_IDLE      = 4'h0,
    PGT_ADDR      = 4'h1,
    PGT_ADDR_ACK  = 4'h3,
    PGT_PTR       = 4'h2,
    PGT_PTR_ACK   = 4'h6,
    PGT_WDATA     = 4'h7,
    PGT_WDATA_ACK = 4'h5,
    PGT_RDATA     = 4'h4,
    PGT_RDATA_ACK = 4'hc
  } pgt_state_t;

  typedef struct packed {
    logic termination_regulator;
    logic shared_switch_or_regulator_rail;
    logic load_switch_b_one;
    logic regulator_a_three;
  } pgt_rails_t;

  typedef struct packed {
    logic control_input_six;
    logic control_input_five;
    logic control_input_four;
    logic control_input_three;
    logic control_input_two;
    logic control_input_one;
  } pgt_ctl_t;

endpackage

// ==== verilog/pgt_regs.svh ====
// Purpose: Register offsets, field positions and reset defaults of the mask bank
// Assumes: Included by bare name from the design files
// Notes:   Reset defaults stand in for factory programming and are overridable
`ifndef PGT_REGS_SVH
`define PGT_REGS_SVH

// ****************************************
// Register offsets
// ****************************************
`define PGT_OUT3_MASK2_OFS   8'hab
`define PGT_CTL_MASK_OFS     8'hac
`define PGT_DISCH_OFS        8'had

// ****************************************
// Second output-three mask fields
// ****************************************
`define PGT_IN5_MSK          7
`define PGT_IN4_MSK          6
`define PGT_IN2_MSK          5
`define PGT_IN1_MSK          4
`define PGT_TERM_MSK         3
`define PGT_SHARED_MSK       2
`define PGT_SWITCH_B_ONE_TREE_MASK         1
`define PGT_REGA3_MSK        0

// ****************************************
// Control-input mask fields
// ****************************************
`define PGT_O1_IN3_MSK       7
`define PGT_O1_IN6_MSK       6
`define PGT_O4_IN3_MSK       5
`define PGT_O4_IN6_MSK       4
`define PGT_O2_IN3_MSK       3
`define PGT_O2_IN6_MSK       2
`define PGT_O3_IN3_MSK       1
`define PGT_O3_IN6_MSK       0

// ****************************************
// Discharge control field
// ****************************************
`define PGT_DISCH_BIT        4

// ****************************************
// Reset defaults (one factory variant)
// ****************************************
`define PGT_OUT3_MASK2_RST   8'hbf
`define PGT_CTL_MASK_RST     8'hab
`define PGT_DISCH_RST        8'h5f

// Serial target address, value is arbitrary
`define PGT_DEV_ADDR         7'h2a

`endif

// ==== verilog/pgt_tree.sv ====
// Purpose: One power-good tree: AND of base_ok and all unmasked sources
// Assumes: Sources are high when good; a mask bit of 1 removes its source
// Notes:   Result is registered
`timescale 1ns/100ps
module pgt_tree #(
  parameter int N = 2
) (
  input  wire logic         clock,
  input  wire logic         nrst,
  input  wire logic [N-1:0] src,
  input  wire logic [N-1:0] mask,
  input  wire logic         base_ok,
  output logic              pg
);
  import pgt_pkg::*;

  if (N < 1)
  begin : g_bad_n
    $error("pgt_tree needs at least one source");
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      pg <= 1'b0;
    else
      pg <= base_ok & (&(src | mask));
  end
endmodule
